// ### design/rpa_pkg.sv
// constants of the pipe address and payload length register bank
package rpa_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [4:0] OFS_P0_ADDR = 5'h0A;
  localparam logic [4:0] OFS_P1_ADDR = 5'h0B;
  localparam logic [4:0] OFS_P2_LOW = 5'h0C;
  localparam logic [4:0] OFS_P3_LOW = 5'h0D;
  localparam logic [4:0] OFS_P4_LOW = 5'h0E;
  localparam logic [4:0] OFS_P5_LOW = 5'h0F;
  localparam logic [4:0] OFS_TX_ADDR = 5'h10;
  localparam logic [4:0] OFS_P0_LEN = 5'h11;
  localparam logic [4:0] OFS_P1_LEN = 5'h12;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [39:0] RST_P0_ADDR = 40'hE7E7E7E7E7;
  localparam logic [39:0] RST_P1_ADDR = 40'hC2C2C2C2C2;
  localparam logic [39:0] RST_TX_ADDR = 40'hE7E7E7E7E7;
  localparam logic [7:0] RST_P2_LOW = 8'hC3;
  localparam logic [7:0] RST_P3_LOW = 8'hC4;
  localparam logic [7:0] RST_P4_LOW = 8'hC5;
  localparam logic [7:0] RST_P5_LOW = 8'hC6;
  localparam logic [5:0] RST_LEN = 6'h00;

  // ************************************************************
  // address width setting codes and byte masks
  // ************************************************************
  localparam logic [1:0] AW_3_BYTES = 2'h1;
  localparam logic [1:0] AW_4_BYTES = 2'h2;
  localparam logic [39:0] MASK_3_BYTES = 40'h0000FFFFFF;
  localparam logic [39:0] MASK_4_BYTES = 40'h00FFFFFFFF;
  localparam logic [39:0] MASK_5_BYTES = 40'hFFFFFFFFFF;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam logic [2:0] ADDR_BYTES = 3'h5;
  localparam int NUM_PIPES = 6;
  localparam int LOW_MSB = 7;
  localparam int UP_LSB = 8;
  localparam int ADDR_MSB = 39;
endpackage

// ### design/rpa_bank.sv
// pipe address, transmit address and payload length register bank
// How it works
// - pipe 1 holds a 40-bit read/write address, every byte reset to C2.
// - only the bytes selected by the address width setting (3 to 5) are used.
// - multi-byte registers move least significant byte first, one byte per strobe.
// - pipes 2 to 5 take bits 39 to 8 from pipe 1 and own only the low byte.
// - the pipe 2 low byte is read/write and resets to C3.
// - the pipe 3 low byte is read/write and resets to C4.
// - the pipe 4 low byte is read/write and resets to C5.
// - the pipe 5 low byte is read/write and resets to C6.
// - the 40-bit transmit address resets to E7 bytes and is applied only as primary transmitter.
// - the pipe 0 payload length is six bits, reset zero, 0 unused, 1 to 32 bytes.
// - the pipe 1 payload length is six bits, reset zero, 0 unused, 1 to 32 bytes.
// - pipe 0 holds a 40-bit read/write address, every byte reset to E7.
`timescale 1ns/1ps
`default_nettype none
module rpa_bank (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register access from the command decoder
  input wire logic acc_start,
  input wire logic [4:0] acc_addr,
  input wire logic byte_wr,
  input wire logic [7:0] byte_wdata,
  input wire logic byte_rd,
  output logic [7:0] byte_rdata,
  output logic byte_rvalid,
  // mode inputs
  input wire logic [1:0] address_width_setting,
  input wire logic primary_transmitter,
  // received packet address
  input wire logic rx_addr_valid,
  input wire logic [39:0] rx_addr,
  output logic match_valid,
  output logic match_hit,
  output logic [2:0] match_pipe,
  // configuration to the packet engine
  output logic [39:0] tx_address,
  output logic [5:0] pipe0_payload_length,
  output logic [5:0] pipe1_payload_length
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [39:0] p0_addr;
    logic [39:0] p1_addr;
    logic [39:0] tx_addr;
    logic [7:0] p2_low;
    logic [7:0] p3_low;
    logic [7:0] p4_low;
    logic [7:0] p5_low;
    logic [5:0] len0;
    logic [5:0] len1;
    logic [4:0] addr;
    logic [2:0] idx;
    logic [7:0] rdata;
    logic rvalid;
    logic [39:0] tx_out;
    logic mvalid;
    logic mhit;
    logic [2:0] mpipe;
  } rpa_state_t;

  rpa_state_t st_reg;
  rpa_state_t st_next;
  logic [39:0] width_mask;
  logic [39:0] eff_addr [rpa_pkg::NUM_PIPES];
  logic [rpa_pkg::NUM_PIPES-1:0] pipe_hit;
  logic [39:0] read_word;
  logic [39:0] read_shift;
  logic [31:0] p1_upper;

  // byte replaced at a given index, least significant byte is index 0
  function automatic logic [39:0] put_byte(input logic [39:0] v, input logic [2:0] i,
                                           input logic [7:0] b);
    logic [39:0] m;
    logic [39:0] d;
    m = 40'h00000000FF << {i, 3'h0};
    d = {32'h00000000, b} << {i, 3'h0};
    return (v & ~m) | d;
  endfunction

  // used bytes of an address from the width setting
  always_comb begin
    unique case (address_width_setting)
      rpa_pkg::AW_3_BYTES: width_mask = rpa_pkg::MASK_3_BYTES;
      rpa_pkg::AW_4_BYTES: width_mask = rpa_pkg::MASK_4_BYTES;
      default: width_mask = rpa_pkg::MASK_5_BYTES;
    endcase
  end

  // effective pipe addresses and per pipe comparison
  assign eff_addr[0] = st_reg.p0_addr;
  assign eff_addr[1] = st_reg.p1_addr;
  // one copy of the upper bytes, so pipes 2 to 5 can never drift from pipe 1
  assign p1_upper = st_reg.p1_addr[rpa_pkg::ADDR_MSB:rpa_pkg::UP_LSB];
  assign eff_addr[2] = {p1_upper, st_reg.p2_low};
  assign eff_addr[3] = {p1_upper, st_reg.p3_low};
  assign eff_addr[4] = {p1_upper, st_reg.p4_low};
  assign eff_addr[5] = {p1_upper, st_reg.p5_low};
  for (genvar g = 0; g < rpa_pkg::NUM_PIPES; g++) begin : g_pipe
    assign pipe_hit[g] = ((rx_addr ^ eff_addr[g]) & width_mask) == 40'h0000000000;
  end

  // word seen by a read of the addressed register
  always_comb begin
    unique case (st_reg.addr)
      rpa_pkg::OFS_P0_ADDR: read_word = st_reg.p0_addr;
      rpa_pkg::OFS_P1_ADDR: read_word = st_reg.p1_addr;
      rpa_pkg::OFS_P2_LOW: read_word = eff_addr[2];
      rpa_pkg::OFS_P3_LOW: read_word = eff_addr[3];
      rpa_pkg::OFS_P4_LOW: read_word = eff_addr[4];
      rpa_pkg::OFS_P5_LOW: read_word = eff_addr[5];
      rpa_pkg::OFS_TX_ADDR: read_word = st_reg.tx_addr;
      rpa_pkg::OFS_P0_LEN: read_word = {34'h0, st_reg.len0};
      rpa_pkg::OFS_P1_LEN: read_word = {34'h0, st_reg.len1};
      default: read_word = 40'h0000000000; // unmapped reads zero
    endcase
    read_shift = read_word >> {st_reg.idx, 3'h0};
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.mvalid = 1'b0;
    // new access restarts at the least significant byte
    if (acc_start) begin
      st_next.addr = acc_addr;
      st_next.idx = 3'h0;
    end else if (byte_wr || byte_rd) begin
      if (st_reg.idx != rpa_pkg::ADDR_BYTES) begin
        st_next.idx = st_reg.idx + 3'h1;
      end
    end
    // read byte, zero past the register end
    if (!acc_start && byte_rd) begin
      st_next.rdata = (st_reg.idx < rpa_pkg::ADDR_BYTES) ? read_shift[7:0] : 8'h00;
      st_next.rvalid = 1'b1;
    end
    // write byte into the addressed register
    if (!acc_start && byte_wr && st_reg.idx < rpa_pkg::ADDR_BYTES) begin
      unique case (st_reg.addr)
        rpa_pkg::OFS_P0_ADDR: begin
          st_next.p0_addr = put_byte(st_reg.p0_addr, st_reg.idx, byte_wdata);
        end
        rpa_pkg::OFS_P1_ADDR: begin
          st_next.p1_addr = put_byte(st_reg.p1_addr, st_reg.idx, byte_wdata);
        end
        rpa_pkg::OFS_TX_ADDR: begin
          st_next.tx_addr = put_byte(st_reg.tx_addr, st_reg.idx, byte_wdata);
        end
        default: begin
          // one-byte registers take index 0 only
          // upper bytes written through pipes 2 to 5 are dropped, they belong to pipe 1
          if (st_reg.idx == 3'h0) begin
            unique case (st_reg.addr)
              rpa_pkg::OFS_P2_LOW: st_next.p2_low = byte_wdata;
              rpa_pkg::OFS_P3_LOW: st_next.p3_low = byte_wdata;
              rpa_pkg::OFS_P4_LOW: st_next.p4_low = byte_wdata;
              rpa_pkg::OFS_P5_LOW: st_next.p5_low = byte_wdata;
              rpa_pkg::OFS_P0_LEN: st_next.len0 = byte_wdata[5:0];
              rpa_pkg::OFS_P1_LEN: st_next.len1 = byte_wdata[5:0];
              default: st_next.len0 = st_reg.len0; // unmapped writes ignored
            endcase
          end
        end
      endcase
    end
    // transmit address applied only as primary transmitter
    st_next.tx_out = primary_transmitter ? (st_reg.tx_addr & width_mask) : 40'h0;
    // lowest numbered matching pipe wins
    if (rx_addr_valid) begin
      st_next.mvalid = 1'b1;
      st_next.mhit = |pipe_hit;
      st_next.mpipe = 3'h0;
      for (int k = rpa_pkg::NUM_PIPES - 1; k >= 0; k--) begin
        if (pipe_hit[k]) begin
          st_next.mpipe = 3'(k);
        end
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.p0_addr <= rpa_pkg::RST_P0_ADDR;
      st_reg.p1_addr <= rpa_pkg::RST_P1_ADDR;
      st_reg.tx_addr <= rpa_pkg::RST_TX_ADDR;
      st_reg.p2_low <= rpa_pkg::RST_P2_LOW;
      st_reg.p3_low <= rpa_pkg::RST_P3_LOW;
      st_reg.p4_low <= rpa_pkg::RST_P4_LOW;
      st_reg.p5_low <= rpa_pkg::RST_P5_LOW;
      st_reg.len0 <= rpa_pkg::RST_LEN;
      st_reg.len1 <= rpa_pkg::RST_LEN;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign byte_rdata = st_reg.rdata;
  assign byte_rvalid = st_reg.rvalid;
  assign match_valid = st_reg.mvalid;
  assign match_hit = st_reg.mhit;
  assign match_pipe = st_reg.mpipe;
  assign tx_address = st_reg.tx_out;
  assign pipe0_payload_length = st_reg.len0;
  assign pipe1_payload_length = st_reg.len1;
endmodule
`default_nettype wire

// ### verification/rpa_bank_asserts.sv
// checker of the pipe address register bank ports
`timescale 1ns/1ps
`default_nettype none
module rpa_bank_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic acc_start,
  input wire logic byte_wr,
  input wire logic byte_rd,
  input wire logic byte_rvalid,
  // modes and outputs
  input wire logic [1:0] address_width_setting,
  input wire logic primary_transmitter,
  input wire logic rx_addr_valid,
  input wire logic match_valid,
  input wire logic match_hit,
  input wire logic [2:0] match_pipe,
  input wire logic [39:0] tx_address,
  input wire logic [5:0] pipe0_payload_length
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // read strobe outside an access start
  sequence rd_strobe_s;
    byte_rd && !acc_start;
  endsequence
  // packet address offered, then its registered answer
  sequence pkt_offer_s;
    rx_addr_valid;
  endsequence
  sequence pkt_answer_s;
    match_valid;
  endsequence
  // transmitter mode with a three byte width
  sequence tx_narrow_s;
    primary_transmitter && address_width_setting == 2'h1;
  endsequence
  rd_answer_a: assert property (rd_strobe_s |=> byte_rvalid)
    else $error("read strobe got no answer");
  rd_cause_a: assert property (byte_rvalid |-> $past(byte_rd && !acc_start))
    else $error("read answer without strobe");
  match_when_a: assert property (pkt_offer_s |=> pkt_answer_s)
    else $error("match result missing");
  match_cause_a: assert property (match_valid |-> $past(rx_addr_valid))
    else $error("match result without packet");
  miss_pipe_a: assert property (match_valid && !match_hit |-> match_pipe == 3'h0)
    else $error("pipe number on a miss");
  tx_gate_a: assert property (!primary_transmitter |=> tx_address == 40'h0)
    else $error("tx address applied while not transmitter");
  tx_width_a: assert property (tx_narrow_s |=> tx_address[39:24] == 16'h0)
    else $error("tx address wider than three bytes");
  len_hold_a: assert property ($changed(pipe0_payload_length) |-> $past(byte_wr))
    else $error("length changed without a write");
endmodule
`default_nettype wire

// ### verification/rpa_host.sv
// host model driving the byte strobes of the register port
`timescale 1ns/1ps
`default_nettype none
module rpa_host (
  // clock
  input wire logic clk_sys,
  // register port
  output logic acc_start,
  output logic [4:0] acc_addr,
  output logic byte_wr,
  output logic [7:0] byte_wdata,
  output logic byte_rd,
  input wire logic [7:0] byte_rdata,
  input wire logic byte_rvalid
);
  // strobes idle from time zero
  initial begin
    {acc_start, acc_addr, byte_wr, byte_wdata, byte_rd} = '0;
  end
  // one access, n bytes back to back, least significant first
  task automatic xfer(input logic [4:0] a, input logic [39:0] d, input int n,
    input bit wr, output logic [39:0] q);
    q = '0;
    @(posedge clk_sys) #1;
    acc_start = 1'b1;
    acc_addr = a;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_sys) #1;
      acc_start = 1'b0;
      if (i > 0 && !wr) q[8*(i-1)+:8] = byte_rvalid ? byte_rdata : 8'hXX;
      byte_wr = wr && i < n;
      byte_rd = !wr && i < n;
      byte_wdata = (wr && i < n) ? d[8*i+:8] : ~byte_wdata;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/rpa_bank_test.sv
// self-checking bench of the pipe address register bank
`timescale 1ns/1ps
`default_nettype none
module rpa_bank_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] address_width_setting = 2'h3;
  logic primary_transmitter = 1'b0;
  logic rx_addr_valid = 1'b0;
  logic [39:0] rx_addr = 40'h0;
  logic acc_start, byte_wr, byte_rd, byte_rvalid, match_valid, match_hit;
  logic [4:0] acc_addr;
  logic [7:0] byte_wdata, byte_rdata;
  logic [2:0] match_pipe;
  logic [39:0] tx_address, q;
  logic [5:0] pipe0_payload_length, pipe1_payload_length;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  rpa_bank i_rpa_bank (.clk_sys, .sys_rst, .acc_start, .acc_addr, .byte_wr, .byte_wdata,
    .byte_rd, .byte_rdata, .byte_rvalid, .address_width_setting, .primary_transmitter,
    .rx_addr_valid, .rx_addr, .match_valid, .match_hit, .match_pipe, .tx_address,
    .pipe0_payload_length, .pipe1_payload_length);
  rpa_host i_rpa_host (.clk_sys, .acc_start, .acc_addr, .byte_wr, .byte_wdata, .byte_rd,
    .byte_rdata, .byte_rvalid);
  // compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one packet address through the match port
  task automatic match(input logic [1:0] aw, input logic [39:0] a, input logic [3:0] exp);
    @(posedge clk_sys) #1;
    address_width_setting = aw;
    rx_addr = a;
    rx_addr_valid = 1'b1;
    @(posedge clk_sys) #1;
    rx_addr_valid = 1'b0;
    check(40'({match_valid, match_hit, match_pipe}), 40'({1'b1, exp}));
  endtask
  // every register reads its power-on value
  task automatic reset_defaults();
    logic [39:0] exp [9] = '{40'hE7E7E7E7E7, 40'hC2C2C2C2C2, 40'hC2C2C2C2C3,
      40'hC2C2C2C2C4, 40'hC2C2C2C2C5, 40'hC2C2C2C2C6, 40'hE7E7E7E7E7, 40'h0, 40'h0};
    for (int k = 0; k < 9; k++) begin
      i_rpa_host.xfer(5'h0A + 5'(k), 40'h0, (k < 7) ? 5 : 1, 1'b0, q);
      check(q, exp[k]);
    end
    check(tx_address, 40'h0);
  endtask
  // pipes 2 to 5 share the pipe 1 upper bytes
  task automatic shared_upper();
    i_rpa_host.xfer(5'h0B, 40'h5A6B7C8D9E, 5, 1'b1, q);
    i_rpa_host.xfer(5'h0C, 40'h3CA5, 2, 1'b1, q);
    i_rpa_host.xfer(5'h0C, 40'h0, 5, 1'b0, q);
    check(q, 40'h5A6B7C8DA5);
    i_rpa_host.xfer(5'h0F, 40'h0, 5, 1'b0, q);
    check(q, 40'h5A6B7C8DC6);
    match(2'h3, 40'h5A6B7C8DA5, 4'hA);
    match(2'h1, 40'h00007C8DA5, 4'hA);
    match(2'h2, 40'hFF6B7C8DC6, 4'hD);
    match(2'h3, 40'hFF6B7C8DC6, 4'h0);
  endtask
  // transmit address gated by mode and width
  task automatic tx_path();
    i_rpa_host.xfer(5'h10, 40'h1234567890, 5, 1'b1, q);
    i_rpa_host.xfer(5'h0A, 40'h1234567890, 5, 1'b1, q);
    match(2'h3, 40'h1234567890, 4'h8);
    primary_transmitter = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(tx_address, 40'h1234567890);
    address_width_setting = 2'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(tx_address, 40'h0000567890);
    primary_transmitter = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(tx_address, 40'h0);
  endtask
  // payload lengths at the range edges
  task automatic payload_len();
    i_rpa_host.xfer(5'h11, 40'h20, 1, 1'b1, q);
    i_rpa_host.xfer(5'h12, 40'h01, 1, 1'b1, q);
    i_rpa_host.xfer(5'h11, 40'h0, 1, 1'b0, q);
    check(q, 40'h20);
    i_rpa_host.xfer(5'h12, 40'h0, 1, 1'b0, q);
    check(q, 40'h01);
    check(40'({pipe0_payload_length, pipe1_payload_length}), 40'h801);
  endtask
  // a reset in mid-run brings every register back to its power-on value
  task automatic mid_reset();
    @(posedge clk_sys) #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    check(40'({pipe0_payload_length, pipe1_payload_length}), 40'h0);
    reset_defaults();
  endtask
  // closing report
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    reset_defaults();
    shared_upper();
    tx_path();
    payload_len();
    mid_reset();
    results();
  end
endmodule
bind rpa_bank rpa_bank_asserts i_rpa_bank_asserts (.clk_sys, .sys_rst, .acc_start,
  .byte_wr, .byte_rd, .byte_rvalid, .address_width_setting, .primary_transmitter,
  .rx_addr_valid, .match_valid, .match_hit, .match_pipe, .tx_address, .pipe0_payload_length);
`default_nettype wire
